// File: kspm_regs.svh
// Register offsets, field positions and reset values for the port mux
`ifndef KSPM_REGS_SVH
`define KSPM_REGS_SVH
`define KSPM_ADR_W 4
`define KSPM_OFF_CTRL 4'h0
`define KSPM_OFF_SCAN 4'h4
`define KSPM_OFF_P3OUT 4'h8
`define KSPM_OFF_STATUS 4'hc
`define KSPM_CTRL_MODE_BIT 0
`define KSPM_CTRL_ROMLESS_BIT 1
`define KSPM_CTRL_XSCAN_BIT 2
`define KSPM_CTRL_RST 8'h00
`define KSPM_SCAN_RST 17'h1ffff
`define KSPM_P3_RST 8'hff
`define KSPM_P1_QB_MASK 8'h0f
`endif

// File: kspm_pkg.sv
// Types shared by the keyboard scan port mux
package kspm_pkg;
	typedef enum logic [2:0] {
		KSPM_IDLE = 3'b001,
		KSPM_ACK = 3'b010,
		KSPM_HOLD = 3'b100
	} kspm_bus_t;
	typedef logic [16:0] kspm_scan_t;
endpackage : kspm_pkg

// File: kspm_port_mux.sv
// Keyboard scan port mux with Wishbone register slave
//
// Decided for this implementation: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "kspm_regs.svh"
module kspm_port_mux #(
	parameter logic [3:0] P1_QB_OPT = 4'h0,
	parameter logic [6:0] P3_OD_OPT = 7'h00,
	parameter logic [6:0] P3_TTL_OPT = 7'h7f
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [`KSPM_ADR_W-1:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	input wire logic xmove_req_in,
	input wire logic xmove_we_in,
	input wire logic [15:0] xmove_addr_in,
	input wire logic [7:0] xmove_wdata_in,
	input wire logic [7:0] port0_in,
	output logic [7:0] port0_out,
	output logic [7:0] port0_oe_out,
	output logic [7:0] port2_out,
	input wire logic [7:0] port1_in,
	input wire logic [7:0] port1_cmp_in,
	output logic [7:0] port1_out,
	output logic [7:0] port1_oe_out,
	input wire logic [7:0] port3_in,
	output logic [7:0] port3_out,
	output logic [7:0] port3_oe_out,
	output logic [7:0] xmove_rdata_out,
	output logic timer2_count_input_out,
	output logic timer2_trigger_input_out,
	output logic [6:0] port3_ttl_sel_out
);
	import kspm_pkg::*;

	typedef struct packed {
		kspm_bus_t bus;
		logic [31:0] dat;
		logic mode;
		logic romless;
		logic extra_scan_en;
		kspm_scan_t scan;
		logic [7:0] p3;
		logic [7:0] p1;
		logic key_pressed_n;
		logic [7:0] p0_o;
		logic [7:0] p0_oe;
		logic [7:0] p2_o;
		logic [7:0] p3_o;
		logic [7:0] p3_oe;
		logic [7:0] rdata;
		logic [7:0] p1_o;
		logic [7:0] p1_oe;
		logic t2c;
		logic t2x;
	} kspm_state_t;

	kspm_state_t state_reg;
	kspm_state_t state_next;

	// Quasi-bidir pin: strong low, weak high seen as not driven
	function automatic logic [7:0] kspm_qb_oe(input logic [7:0] val,
		input logic [7:0] en);
		kspm_qb_oe = ~val & en;
	endfunction : kspm_qb_oe

	logic [3:0] p1_qb;
	logic [7:0] p1_qb_full;
	logic [7:0] p3_od_full;
	logic scan_active;
	logic keyb_masked;

	assign p1_qb = P1_QB_OPT & 4'(`KSPM_P1_QB_MASK);
	assign p1_qb_full = {4'h0, p1_qb};
	assign p3_od_full = {P3_OD_OPT[6:2], 1'b0, P3_OD_OPT[1:0]};
	assign keyb_masked = state_reg.mode & ~state_reg.romless;
	assign scan_active = ~&state_reg.scan;

	always_comb
	begin
		logic xstrobe;
		logic [7:0] p3v;
		logic [7:0] row_hit;
		logic wr_ok;
		xstrobe = 1'b0;
		p3v = 8'h00;
		row_hit = 8'h00;
		wr_ok = 1'b0;
		state_next = state_reg;
		// Bus slave: one ack cycle, then drop until request released
		case (state_reg.bus)
			KSPM_IDLE:
			begin
				if (wb_cyc_in && wb_stb_in)
				begin
					state_next.bus = KSPM_ACK;
					state_next.dat = 32'h0000_0000;
					case (wb_adr_in)
						`KSPM_OFF_CTRL:
							state_next.dat[2:0] = {state_reg.extra_scan_en,
								state_reg.romless, state_reg.mode};
						`KSPM_OFF_SCAN:
							state_next.dat[16:0] = state_reg.scan;
						`KSPM_OFF_P3OUT:
							state_next.dat[15:0] = {state_reg.p1, state_reg.p3};
						`KSPM_OFF_STATUS:
							state_next.dat[23:0] = {port1_cmp_in, port1_in,
								port3_in[7:3], state_reg.key_pressed_n,
								port3_in[1:0]};
						default:
							state_next.dat = 32'h0000_0000;
					endcase
				end
			end
			KSPM_ACK:
			begin
				state_next.bus = KSPM_HOLD;
				// Write lands on the edge that samples ack, request still held
				wr_ok = wb_cyc_in && wb_stb_in && wb_we_in;
				if (wr_ok && wb_adr_in == `KSPM_OFF_CTRL && wb_sel_in[0])
				begin
					state_next.mode = wb_dat_in[`KSPM_CTRL_MODE_BIT];
					state_next.romless = wb_dat_in[`KSPM_CTRL_ROMLESS_BIT];
					state_next.extra_scan_en = wb_dat_in[`KSPM_CTRL_XSCAN_BIT];
				end
				if (wr_ok && wb_adr_in == `KSPM_OFF_SCAN)
				begin
					if (wb_sel_in[0])
						state_next.scan[7:0] = wb_dat_in[7:0];
					if (wb_sel_in[1])
						state_next.scan[15:8] = wb_dat_in[15:8];
					if (wb_sel_in[2])
						state_next.scan[16] = wb_dat_in[16];
				end
				if (wr_ok && wb_adr_in == `KSPM_OFF_P3OUT)
				begin
					if (wb_sel_in[0])
						state_next.p3 = wb_dat_in[7:0];
					if (wb_sel_in[1])
						state_next.p1 = wb_dat_in[15:8];
				end
			end
			KSPM_HOLD:
				if (!(wb_cyc_in && wb_stb_in))
					state_next.bus = KSPM_IDLE;
			default:
				state_next.bus = KSPM_IDLE;
		endcase

		// Key detect from comparators while a line is low, flag forced high otherwise
		row_hit = ~port1_cmp_in & ~p1_qb_full;
		state_next.key_pressed_n = scan_active ? ~|row_hit : 1'b1;

		// Port0 and port2
		if (keyb_masked)
		begin
			state_next.p0_o = state_reg.scan[7:0];
			state_next.p0_oe = 8'hff;
			state_next.p2_o = state_reg.scan[15:8];
		end
		else if (xmove_req_in && !state_reg.mode)
		begin
			state_next.p0_o = xmove_we_in ? xmove_wdata_in : xmove_addr_in[7:0];
			state_next.p0_oe = xmove_we_in ? 8'hff : 8'h00;
			state_next.p2_o = xmove_addr_in[15:8];
		end
		else if (state_reg.mode)
		begin
			// Romless keyboard mode: bus stays idle, scan via external ports
			state_next.p0_oe = 8'h00;
			state_next.p2_o = 8'hff;
		end
		else
		begin
			state_next.p0_oe = 8'h00;
			state_next.p2_o = state_reg.scan[15:8];
		end
		if (xmove_req_in && !xmove_we_in)
			state_next.rdata = port0_in;

		// Port3: strobes only outside keyboard mode
		xstrobe = xmove_req_in && !state_reg.mode;
		p3v = state_reg.p3;
		if (state_reg.extra_scan_en)
			p3v[4] = state_reg.scan[16];
		if (xstrobe && state_reg.romless)
		begin
			p3v[7] = xmove_we_in;
			p3v[6] = ~xmove_we_in;
		end
		// Pin follows the flag's next value so the hit shows one cycle later
		p3v[2] = state_next.key_pressed_n;
		state_next.p3_o = p3v;
		state_next.p3_oe = kspm_qb_oe(p3v, 8'hff) | (~p3_od_full & p3v);
		state_next.p3_oe[2] = 1'b1;

		// Port1 low nibble as quasi-bidir by option
		state_next.p1_o = state_reg.p1 | ~p1_qb_full;
		state_next.p1_oe = kspm_qb_oe(state_reg.p1, p1_qb_full);
		state_next.t2c = p1_qb[0] & port1_in[0];
		state_next.t2x = p1_qb[1] & port1_in[1];
	end

	always_ff @(posedge clock_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			state_reg <= '0;
			state_reg.bus <= KSPM_IDLE;
			state_reg.mode <= 1'b0;
			state_reg.scan <= `KSPM_SCAN_RST;
			state_reg.p3 <= `KSPM_P3_RST;
			state_reg.p1 <= 8'hff;
			state_reg.key_pressed_n <= 1'b1;
			state_reg.p2_o <= 8'hff;
			state_reg.p3_o <= `KSPM_P3_RST;
			state_reg.p1_o <= 8'hff;
		end
		else
			state_reg <= state_next;
	end

	// One-hot code: the ack state's own bit is the ack flop
	assign wb_ack_out = state_reg.bus[1];
	assign wb_dat_out = state_reg.dat;
	assign port0_out = state_reg.p0_o;
	assign port0_oe_out = state_reg.p0_oe;
	assign port2_out = state_reg.p2_o;
	assign port1_out = state_reg.p1_o;
	assign port1_oe_out = state_reg.p1_oe;
	assign port3_out = state_reg.p3_o;
	assign port3_oe_out = state_reg.p3_oe;
	assign xmove_rdata_out = state_reg.rdata;
	assign timer2_count_input_out = state_reg.t2c;
	assign timer2_trigger_input_out = state_reg.t2x;
	assign port3_ttl_sel_out = P3_TTL_OPT;

	chk_mode_reset: assert property (@(posedge clock_in)
		$rose(rst_n_in) |-> !state_reg.mode)
		else $error("mode flag not clear after reset");
	chk_key_low: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(scan_active && ~|(~port1_cmp_in & ~p1_qb_full)) |=>
		port3_out[2])
		else $error("key pressed output wrong");
	chk_key_hit: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(scan_active && |(~port1_cmp_in & ~p1_qb_full)) |=>
		!port3_out[2])
		else $error("key pressed not low on hit");
	chk_no_strobe: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(state_reg.mode && xmove_req_in) |=>
		port3_out[7:6] == $past(state_reg.p3[7:6]))
		else $error("strobe in keyboard mode");
	chk_p0_scan: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		keyb_masked |=> port0_out == $past(state_reg.scan[7:0]))
		else $error("port0 not scan in keyboard mode");
	chk_p2_scan: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		keyb_masked |=> port2_out == $past(state_reg.scan[15:8]))
		else $error("port2 not scan");
	chk_rd_pulse: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(!state_reg.mode && state_reg.romless && xmove_req_in && !xmove_we_in)
		|=> !port3_out[7])
		else $error("no read strobe");
	chk_p1_upper: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		port1_oe_out[7:4] == 4'h0)
		else $error("upper port1 driven");
	chk_masked_quiet: assert property (@(posedge clock_in) disable iff (!rst_n_in)
		(!state_reg.romless && xmove_req_in) |=>
		port3_out[7:6] == $past(state_reg.p3[7:6]))
		else $error("strobe on masked part");
endmodule : kspm_port_mux

// File: kspm_matrix_model.sv
// Behavioural key matrix with one closed switch, no blocking diodes
`timescale 1ns/1ps
module kspm_matrix_model (
	input wire logic [16:0] scan_in,
	input wire logic press_in,
	input wire logic [4:0] col_in,
	input wire logic [2:0] row_in,
	output logic [7:0] cmp_out
);
	// Return line pulls low only while its column is driven low
	always_comb
	begin
		cmp_out = 8'hff;
		if (press_in && scan_in[col_in] == 1'b0)
			cmp_out[row_in] = 1'b0;
	end
endmodule : kspm_matrix_model

// File: kspm_port_mux_tb.sv
// Self-checking bench for the keyboard scan port mux
`timescale 1ns/1ps
`include "kspm_regs.svh"
module kspm_port_mux_tb;
	logic clock_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, xreq = 1'b0, xwe = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, dat_o;
	logic ack, t2c, t2t, press = 1'b0;
	logic [7:0] p0o, p0oe, p2o, p1o, p1oe, p3o, p3oe, xrd, cmp;
	logic [6:0] ttl;
	logic [4:0] col = 5'h03;
	logic [3:0] sel = 4'hf;
	logic [7:0] p1in = 8'hff;
	int err_count = 0, cmp_count = 0, cycles = 0;
	always #20 clock_in = ~clock_in;
	kspm_port_mux #(.P3_OD_OPT(7'h01)) u_kspm_port_mux (.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
		.wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(dat_o),
		.wb_ack_out(ack), .xmove_req_in(xreq), .xmove_we_in(xwe),
		.xmove_addr_in(16'hffff), .xmove_wdata_in(8'h3c),
		.port0_in(8'h5a), .port0_out(p0o), .port0_oe_out(p0oe),
		.port2_out(p2o), .port1_in(p1in), .port1_cmp_in(cmp),
		.port1_out(p1o), .port1_oe_out(p1oe), .port3_in(8'hff),
		.port3_out(p3o), .port3_oe_out(p3oe), .xmove_rdata_out(xrd),
		.timer2_count_input_out(t2c), .timer2_trigger_input_out(t2t),
		.port3_ttl_sel_out(ttl));
	kspm_matrix_model u_kspm_matrix_model (.scan_in({p3o[4], p2o, p0o}),
		.press_in(press), .col_in(col), .row_in(3'h5), .cmp_out(cmp));
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic finish_test;
		$display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : finish_test
	// Request held until ack is seen at a rising edge
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_in);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
			@(posedge clock_in);
		while (ack !== 1'b1);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic settle;
		repeat (3) @(posedge clock_in);
		#1;
	endtask : settle
	// One move cycle; checks strobes and masked port0 drive mid-move
	task automatic xmove(input logic w, input logic [1:0] strb,
		input logic [15:0] m, input logic [15:0] e);
		@(posedge clock_in);
		xreq <= 1'b1;
		xwe <= w;
		@(posedge clock_in);
		#1;
		check(p3o[7:6], strb);
		check({p0oe, p0o} & m, e);
		@(posedge clock_in);
		xreq <= 1'b0;
		xwe <= 1'b0;
	endtask : xmove
	always @(posedge clock_in)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			err_count++;
			finish_test();
		end
	end
	initial
	begin
		repeat (8) @(posedge clock_in);
		rst_n_in <= 1'b1;
		wb(1'b0, `KSPM_OFF_CTRL, 32'h0);
		check(rdat, 32'h0);
		check({p2o, p3o[2], p1oe}, {8'hff, 1'b1, 8'h00});
		check({t2c, t2t, p1o}, {2'b00, 8'hff});
		check({p3oe, ttl}, {8'hfe, 7'h7f});
		wb(1'b0, 4'h2, 32'h0);
		check(rdat, 32'h0);
		xmove(1'b1, 2'b11, 16'hff00, 16'hff00);
		wb(1'b1, `KSPM_OFF_CTRL, 32'h2);
		xmove(1'b0, 2'b01, 16'hffff, 16'h00ff);
		check(xrd, 8'h5a);
		$display("test general mode done");
		wb(1'b1, `KSPM_OFF_CTRL, 32'h1);
		press <= 1'b1;
		wb(1'b1, `KSPM_OFF_SCAN, 32'h1fff7);
		settle();
		check({p0oe, p0o, p2o}, 24'hfff7ff);
		check(p3o[2], 1'b0);
		wb(1'b0, `KSPM_OFF_STATUS, 32'h0);
		check(rdat, 32'hdffffb);
		xmove(1'b0, 2'b11, 16'hffff, 16'hfff7);
		wb(1'b1, `KSPM_OFF_SCAN, 32'h1ffff);
		wb(1'b1, `KSPM_OFF_SCAN, 32'h1fdff);
		settle();
		check({p2o, p3o[2]}, {8'hfd, 1'b1});
		$display("test keyboard mode done");
		wb(1'b1, `KSPM_OFF_CTRL, 32'h5);
		wb(1'b1, `KSPM_OFF_SCAN, 32'h1ffff);
		col <= 5'h10;
		wb(1'b1, `KSPM_OFF_SCAN, 32'h0ffff);
		settle();
		check({p3o[4], p3o[2]}, 2'b00);
		$display("test extra scan line done");
		sel <= 4'h2;
		wb(1'b1, `KSPM_OFF_P3OUT, 32'h0000_0000);
		sel <= 4'hf;
		wb(1'b0, `KSPM_OFF_P3OUT, 32'h0);
		check(rdat, 32'h0000_00ff);
		check({p1o, p1oe}, 16'hff00);
		$display("test byte lanes done");
		finish_test();
	end
endmodule : kspm_port_mux_tb
